// [rtl/ext_regs.sv]
// Extension lock register, extended sequencer mode and aperture decode
// What this block does
// - Writing xxx1x010 to lock unlocks extensions; lock then reads 00010010.
// - Any other lock write relocks extensions; lock then reads 00001111.
// - Variant without lock register keeps extensions always accessible.
// - Segment field zero decodes only legacy A/B windows per map select.
// - Nonzero segment claims 1 Mbyte where address 23:20 equals segment.
// - Two-megabyte enable claims aligned 2 Mbyte, ignoring segment bit zero.
// - One-to-one map only with full 1 Mbyte and chaining; else wrap.
`timescale 1ns/1ps
`include "ext_regs_defines.svh"

module ext_regs #(
    parameter bit HAS_LOCK = 1'b1                            // Lock register built
) (
    input  wire logic                   clock_in,            // Host bus clock
    input  wire logic                   reset_n_in,          // Async reset, active low
    input  wire ext_regs_pkg::host_io_t io_in,               // Sequencer port access
    output logic [7:0]                  rdata_out,           // Read data, registered
    output logic                        rdata_valid_out,     // Read data strobe
    output logic                        extensions_open_out, // Extensions accessible
    output logic [3:0]                  memory_segment_field_out, // Segment field
    input  wire logic                   two_megabyte_aperture_enable_in, // 2M mode
    input  wire logic [1:0]             legacy_memory_map_select_in, // Legacy window
    input  wire logic                   full_megabyte_in,    // 1M memory installed
    input  wire logic                   chain4_in,           // Chained 256-colour
    input  wire ext_regs_pkg::mem_req_t mem_req_in,          // Memory access
    output ext_regs_pkg::mem_ans_t      mem_ans_out,         // Decode answer
    output logic                        mem_ans_valid_out    // Answer strobe
);

    logic [7:0] index_q;
    logic       unlocked_q;
    logic [7:0] mode_q;
    logic       open;
    logic       unlock_match;
    logic [7:0] lock_rd;
    logic [7:0] rd_d;

    // ======================================================================
    // Access control
    assign unlock_match = ((io_in.wdata & `EXT_UNLOCK_MASK) == `EXT_UNLOCK_VALUE);
    assign open         = HAS_LOCK ? unlocked_q : 1'b1;
    assign lock_rd      = unlocked_q ? `EXT_LOCK_RD_OPEN : `EXT_LOCK_RD_SHUT;

    assign extensions_open_out      = open;
    assign memory_segment_field_out = mode_q[`EXT_SEG_MSB:`EXT_SEG_LSB];

    // ======================================================================
    // Index register
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            index_q <= 8'h00;
        end else if (io_in.index_wr) begin
            index_q <= io_in.wdata;
        end
    end

    // ======================================================================
    // Lock register
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            unlocked_q <= 1'b0;
        end else if (HAS_LOCK && io_in.data_wr && index_q == `EXT_LOCK_INDEX) begin
            unlocked_q <= unlock_match;
        end
    end

    // ======================================================================
    // Extended sequencer mode register, writable only while open
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_q <= `EXT_MODE_RESET;
        end else if (open && io_in.data_wr && index_q == `EXT_MODE_INDEX) begin
            mode_q <= io_in.wdata;
        end
    end

    // ======================================================================
    // Read path
    always_comb begin
        rd_d = `EXT_UNMAPPED_RD;
        if (HAS_LOCK && index_q == `EXT_LOCK_INDEX) begin
            rd_d = lock_rd;
        end else if (open && index_q == `EXT_MODE_INDEX) begin
            // Locked extension reads return zero rather than stale state
            rd_d = mode_q & `EXT_MODE_RD_MASK;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out       <= 8'h00;
            rdata_valid_out <= 1'b0;
        end else begin
            rdata_valid_out <= io_in.data_rd;
            if (io_in.data_rd) begin
                rdata_out <= rd_d;
            end
        end
    end

    // ======================================================================
    // Memory decode
    aperture_decode u_decode (
        .clock_in                        (clock_in),
        .reset_n_in                      (reset_n_in),
        .req_in                          (mem_req_in),
        .memory_segment_field_in         (memory_segment_field_out),
        .two_megabyte_aperture_enable_in (two_megabyte_aperture_enable_in),
        .legacy_memory_map_select_in     (legacy_memory_map_select_in),
        .one_to_one_in                   (full_megabyte_in & chain4_in),
        .ans_out                         (mem_ans_out),
        .ans_valid_out                   (mem_ans_valid_out)
    );

    // ======================================================================
    // Checks: sequences
    // Each step is one sampled edge of the host port
    sequence lock_write_s(bit m);
        HAS_LOCK && io_in.data_wr && index_q == `EXT_LOCK_INDEX && unlock_match == m;
    endsequence

    sequence lock_read_s;
        io_in.data_rd && !io_in.data_wr && !io_in.index_wr && index_q == `EXT_LOCK_INDEX;
    endsequence

    sequence mode_write_s;
        extensions_open_out && io_in.data_wr && index_q == `EXT_MODE_INDEX;
    endsequence

    sequence mode_read_s;
        io_in.data_rd && !io_in.data_wr && !io_in.index_wr && index_q == `EXT_MODE_INDEX;
    endsequence

    // ======================================================================
    // Checks: lock register
    unlock_read_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        lock_write_s(1'b1) ##1 lock_read_s |=> rdata_out == `EXT_LOCK_RD_OPEN)
        else $error("unlocked lock reads wrong");

    relock_read_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        lock_write_s(1'b0) ##1 lock_read_s |=> rdata_out == `EXT_LOCK_RD_SHUT)
        else $error("locked lock reads wrong");

    unlock_opens_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        lock_write_s(1'b1) |=> extensions_open_out)
        else $error("unlock did not open");

    relock_closes_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        lock_write_s(1'b0) |=> !extensions_open_out)
        else $error("relock did not close");

    // Only a lock write may move the lock, so stray traffic cannot open it
    lock_hold_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        !(io_in.data_wr && index_q == `EXT_LOCK_INDEX) |=> $stable(extensions_open_out))
        else $error("lock moved without lock write");

    open_lock_read_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (HAS_LOCK && extensions_open_out) and lock_read_s |=> rdata_out == `EXT_LOCK_RD_OPEN)
        else $error("open lock reads wrong");

    shut_lock_read_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (HAS_LOCK && !extensions_open_out) and lock_read_s |=> rdata_out == `EXT_LOCK_RD_SHUT)
        else $error("shut lock reads wrong");

    reset_locked_a: assert property (@(posedge clock_in)
        HAS_LOCK && $rose(reset_n_in) |-> !extensions_open_out)
        else $error("not locked after reset");

    no_lock_open_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        !HAS_LOCK |-> extensions_open_out)
        else $error("lockless variant closed");

    lockless_lock_read_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (!HAS_LOCK) and lock_read_s |=> rdata_out == `EXT_UNMAPPED_RD)
        else $error("lockless lock index not empty");

    // ======================================================================
    // Checks: extended sequencer mode register
    locked_write_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        !extensions_open_out && io_in.data_wr && index_q == `EXT_MODE_INDEX
        |=> $stable(mode_q))
        else $error("mode written while locked");

    mode_store_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        mode_write_s ##1 mode_read_s |=> rdata_out == ($past(io_in.wdata, 2) & `EXT_MODE_RD_MASK))
        else $error("mode readback wrong");

    seg_follow_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        mode_write_s |=> memory_segment_field_out == $past(io_in.wdata[`EXT_SEG_MSB:`EXT_SEG_LSB]))
        else $error("segment field not stored");

    locked_mode_read_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        (!extensions_open_out) and mode_read_s |=> rdata_out == `EXT_UNMAPPED_RD)
        else $error("locked mode read not empty");

    open_mode_read_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        extensions_open_out and mode_read_s |=> rdata_out == ($past(mode_q) & `EXT_MODE_RD_MASK))
        else $error("open mode read wrong");

    lockless_write_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        !HAS_LOCK && io_in.data_wr && index_q == `EXT_MODE_INDEX |=> mode_q == $past(io_in.wdata))
        else $error("lockless mode write lost");

    // Segment must start at zero so memory decode begins in legacy windows
    reset_segment_a: assert property (@(posedge clock_in)
        $rose(reset_n_in) |-> memory_segment_field_out == 4'h0 && !rdata_valid_out)
        else $error("mode not cleared by reset");

    // ======================================================================
    // Checks: read port timing
    read_strobe_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        io_in.data_rd |=> rdata_valid_out)
        else $error("read strobe missing");

    // Read data stands until the next read of the data port
    rdata_hold_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        !io_in.data_rd |=> $stable(rdata_out))
        else $error("read data moved without read");

endmodule : ext_regs

// [pkg/ext_regs_defines.svh]
// Constants for the extension lock and extended sequencer mode registers
`ifndef EXT_REGS_DEFINES_SVH
`define EXT_REGS_DEFINES_SVH

// ==========================================================================
// Register indices behind the sequencer data port
`define EXT_LOCK_INDEX        8'h06
`define EXT_MODE_INDEX        8'h07

// ==========================================================================
// Lock register patterns
`define EXT_UNLOCK_MASK       8'h17
`define EXT_UNLOCK_VALUE      8'h12
`define EXT_LOCK_RD_OPEN      8'h12
`define EXT_LOCK_RD_SHUT      8'h0f

// ==========================================================================
// Extended sequencer mode fields and reset values
`define EXT_MODE_RESET        8'h00
`define EXT_MODE_RD_MASK      8'hf7
`define EXT_SEG_MSB           7
`define EXT_SEG_LSB           4
`define EXT_UNMAPPED_RD       8'h00

// ==========================================================================
// Legacy window selects and aperture wrap
`define EXT_MAP_AB            2'h0
`define EXT_MAP_A             2'h1
`define EXT_MAP_B0            2'h2
`define EXT_MAP_B8            2'h3
`define EXT_WRAP_MASK         21'h03ffff

`endif

// [pkg/ext_regs_pkg.sv]
// Types shared by the extension register bank and its aperture decoder
package ext_regs_pkg;

    // ======================================================================
    // Host I/O access on the indexed sequencer port
    typedef struct packed {
        logic       index_wr;   // Write of the index port
        logic       data_wr;    // Write of the data port
        logic       data_rd;    // Read of the data port
        logic [7:0] wdata;      // Write data
    } host_io_t;

    // ======================================================================
    // Host memory access to be claimed or ignored
    typedef struct packed {
        logic        valid;     // Memory cycle present
        logic [23:0] addr;      // Host address
    } mem_req_t;

    typedef struct packed {
        logic        claim;     // Device responds
        logic        linear;    // Claimed by a linear aperture
        logic [20:0] offset;    // Display memory offset
    } mem_ans_t;

endpackage : ext_regs_pkg

// [rtl/aperture_decode.sv]
// Display memory address decode: legacy windows or linear aperture
`timescale 1ns/1ps
`include "ext_regs_defines.svh"

module aperture_decode (
    input  wire logic                  clock_in,         // Host bus clock
    input  wire logic                  reset_n_in,       // Async reset, active low
    input  wire ext_regs_pkg::mem_req_t req_in,          // Memory access
    input  wire logic [3:0]            memory_segment_field_in,      // Segment
    input  wire logic                  two_megabyte_aperture_enable_in, // 2M mode
    input  wire logic [1:0]            legacy_memory_map_select_in,  // Window
    input  wire logic                  one_to_one_in,    // Full 1M and chained
    output ext_regs_pkg::mem_ans_t     ans_out,          // Registered answer
    output logic                       ans_valid_out     // Answer strobe
);

    logic        linear_mode;
    logic        hit_linear;
    logic        hit_legacy;
    logic [20:0] raw_offset;
    logic [20:0] offset;

    // ======================================================================
    // Window selection
    always_comb begin
        linear_mode = (memory_segment_field_in != 4'h0);
        if (two_megabyte_aperture_enable_in) begin
            // Low segment bit is a don't care, so odd values round down
            hit_linear = (req_in.addr[23:21] == memory_segment_field_in[3:1]);
            raw_offset = req_in.addr[20:0];
        end else begin
            hit_linear = (req_in.addr[23:20] == memory_segment_field_in);
            raw_offset = {1'b0, req_in.addr[19:0]};
        end
        hit_legacy = 1'b0;
        if (req_in.addr[23:17] == 7'h05) begin
            unique case (legacy_memory_map_select_in)
                `EXT_MAP_AB: hit_legacy = 1'b1;
                `EXT_MAP_A:  hit_legacy = ~req_in.addr[16];
                `EXT_MAP_B0: hit_legacy = req_in.addr[16] & ~req_in.addr[15];
                `EXT_MAP_B8: hit_legacy = req_in.addr[16] & req_in.addr[15];
            endcase
        end
        // Whole range is still claimed; short memory just wraps
        offset = one_to_one_in ? raw_offset : (raw_offset & `EXT_WRAP_MASK);
    end

    // ======================================================================
    // Registered answer
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ans_out       <= '0;
            ans_valid_out <= 1'b0;
        end else begin
            ans_valid_out <= req_in.valid;
            ans_out.claim  <= req_in.valid & (linear_mode ? hit_linear : hit_legacy);
            ans_out.linear <= req_in.valid & linear_mode & hit_linear;
            ans_out.offset <= linear_mode ? offset : {4'h0, req_in.addr[16:0]};
        end
    end

    // ======================================================================
    // Checks
    seg_claim_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        req_in.valid && memory_segment_field_in != 4'h0 && !two_megabyte_aperture_enable_in
        |=> ans_out.claim == ($past(req_in.addr[23:20]) == $past(memory_segment_field_in)))
        else $error("linear aperture claim wrong");

    two_meg_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        req_in.valid && memory_segment_field_in != 4'h0 && two_megabyte_aperture_enable_in
        |=> ans_out.claim == ($past(req_in.addr[23:21]) == $past(memory_segment_field_in[3:1])))
        else $error("two megabyte claim wrong");

    legacy_only_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        req_in.valid && memory_segment_field_in == 4'h0 && req_in.addr[23:17] != 7'h05
        |=> !ans_out.claim)
        else $error("legacy claim outside A/B");

    wrap_offset_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        req_in.valid && memory_segment_field_in != 4'h0 && !one_to_one_in
        |=> ans_out.offset[20:18] == 3'h0)
        else $error("offset did not wrap");

endmodule : aperture_decode

// [test/host_model.sv]
// Host processor model driving the sequencer I/O port and memory cycles
`timescale 1ns/1ps

module host_model (
    input  wire logic                 clock_in, // Host bus clock
    output ext_regs_pkg::host_io_t    io_out,   // Sequencer port access
    output ext_regs_pkg::mem_req_t    req_out   // Memory cycle
);
    // ======================================================================
    // Idle bus starts at zero and after each cycle shows inverted data, so a stale value is never mistaken
    initial begin
        io_out  = '0;
        req_out = '0;
    end

    task automatic cyc(input logic iw, input logic dw, input logic dr, input logic [7:0] wd);
        @(posedge clock_in);
        #1;
        io_out = '{iw, dw, dr, wd};
        @(posedge clock_in);
        #1;
        io_out = '{1'b0, 1'b0, 1'b0, ~wd};
    endtask : cyc

    task automatic write_reg(input logic [7:0] idx, input logic [7:0] val);
        cyc(1'b1, 1'b0, 1'b0, idx);
        cyc(1'b0, 1'b1, 1'b0, val);
    endtask : write_reg

    task automatic mem(input logic [23:0] addr);
        @(posedge clock_in);
        #1;
        req_out = '{1'b1, addr};
        @(posedge clock_in);
        #1;
        req_out = '{1'b0, ~addr};
    endtask : mem
endmodule : host_model

// [test/ext_regs_tb.sv]
// Self-checking bench for the extension lock, mode register and aperture decode
`timescale 1ns/1ps

module ext_regs_tb;
    logic                   clock_in   = 1'b0;
    logic                   reset_n_in = 1'b0;
    ext_regs_pkg::host_io_t io;
    ext_regs_pkg::mem_req_t req;
    ext_regs_pkg::mem_ans_t ans, ans_b;
    logic [7:0]             rdata, rdata_b;
    logic                   rvalid, rvalid_b, open, open_b, avalid, avalid_b;
    logic [3:0]             seg, seg_b;
    logic                   tm    = 1'b0;
    logic [1:0]             map   = 2'h0;
    logic                   full  = 1'b0;
    logic                   chain = 1'b0;
    int                     bad_count    = 0;
    int                     total_checks = 0;

    typedef struct packed {
        logic [3:0] s; logic t; logic [1:0] m; logic f; logic c;
        logic [23:0] a; logic cl; logic ln; logic [20:0] o;
    } row_t;

    // ======================================================================
    // Decode cases: segment, 2M, map, full, chain, address, expected answer
    row_t rows [12] = '{
        '{4'h3, 1'b0, 2'h0, 1'b1, 1'b1, 24'h3abcde, 1'b1, 1'b1, 21'h0abcde},
        '{4'h3, 1'b0, 2'h0, 1'b1, 1'b1, 24'h4abcde, 1'b0, 1'b0, 21'h000000},
        '{4'h3, 1'b0, 2'h0, 1'b1, 1'b0, 24'h3abcde, 1'b1, 1'b1, 21'h02bcde},
        '{4'h3, 1'b0, 2'h0, 1'b0, 1'b1, 24'h3abcde, 1'b1, 1'b1, 21'h02bcde},
        '{4'h3, 1'b1, 2'h0, 1'b1, 1'b1, 24'h2abcde, 1'b1, 1'b1, 21'h0abcde},
        '{4'h3, 1'b1, 2'h0, 1'b1, 1'b1, 24'h3abcde, 1'b1, 1'b1, 21'h1abcde},
        '{4'h0, 1'b0, 2'h0, 1'b1, 1'b1, 24'h0b1234, 1'b1, 1'b0, 21'h011234},
        '{4'h0, 1'b0, 2'h1, 1'b1, 1'b1, 24'h0b1234, 1'b0, 1'b0, 21'h000000},
        '{4'h0, 1'b0, 2'h2, 1'b1, 1'b1, 24'h0b1234, 1'b1, 1'b0, 21'h011234},
        '{4'h0, 1'b0, 2'h3, 1'b1, 1'b1, 24'h0b1234, 1'b0, 1'b0, 21'h000000},
        '{4'h0, 1'b0, 2'h3, 1'b1, 1'b1, 24'h0b9000, 1'b1, 1'b0, 21'h019000},
        '{4'h0, 1'b0, 2'h1, 1'b1, 1'b1, 24'h3abcde, 1'b0, 1'b0, 21'h000000}
    };

    always #2 clock_in = ~clock_in;

    host_model host_model_inst (.clock_in(clock_in), .io_out(io), .req_out(req));

    ext_regs ext_regs_inst (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .io_in(io), .rdata_out(rdata),
        .rdata_valid_out(rvalid), .extensions_open_out(open), .memory_segment_field_out(seg),
        .two_megabyte_aperture_enable_in(tm), .legacy_memory_map_select_in(map),
        .full_megabyte_in(full), .chain4_in(chain), .mem_req_in(req),
        .mem_ans_out(ans), .mem_ans_valid_out(avalid));

    // Lockless build shares the host, so both see identical traffic
    ext_regs #(.HAS_LOCK(1'b0)) lockless_inst (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .io_in(io), .rdata_out(rdata_b),
        .rdata_valid_out(rvalid_b), .extensions_open_out(open_b),
        .memory_segment_field_out(seg_b), .two_megabyte_aperture_enable_in(tm),
        .legacy_memory_map_select_in(map), .full_megabyte_in(full), .chain4_in(chain),
        .mem_req_in(req), .mem_ans_out(ans_b), .mem_ans_valid_out(avalid_b));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] exp_b);
        host_model_inst.cyc(1'b1, 1'b0, 1'b0, idx);
        host_model_inst.cyc(1'b0, 1'b0, 1'b1, 8'h00);
        check(rvalid, 1'b1);
        check(rvalid_b, 1'b1);
        check(rdata, exp);
        check(rdata_b, exp_b);
    endtask : rd

    task automatic wrap_up();
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (8) @(posedge clock_in);
        #1;
        reset_n_in = 1'b1;
        check(open, 1'b0);
        check(open_b, 1'b1);
        check({rdata, rvalid, avalid, seg}, 14'h0000);
        rd(8'h06, 8'h0f, 8'h00);
        host_model_inst.write_reg(8'h07, 8'h50);
        check(seg, 4'h0);
        check(seg_b, 4'h5);
        rd(8'h07, 8'h00, 8'h50);
        host_model_inst.write_reg(8'h06, 8'hf2);
        check(open, 1'b1);
        rd(8'h06, 8'h12, 8'h00);
        foreach (rows[i]) begin
            host_model_inst.write_reg(8'h07, {rows[i].s, 4'h0});
            {tm, map, full, chain} = {rows[i].t, rows[i].m, rows[i].f, rows[i].c};
            check(seg, rows[i].s);
            host_model_inst.mem(rows[i].a);
            check(avalid, 1'b1);
            check(ans.claim, rows[i].cl);
            check({avalid_b, ans_b.claim}, {1'b1, rows[i].cl});
            if (rows[i].cl) begin
                check({ans.linear, ans.offset}, {rows[i].ln, rows[i].o});
                check({ans_b.linear, ans_b.offset}, {rows[i].ln, rows[i].o});
            end
        end
        host_model_inst.write_reg(8'h07, 8'h30);
        host_model_inst.write_reg(8'h06, 8'h1a);
        check(open, 1'b1);
        host_model_inst.write_reg(8'h06, 8'h13);
        check(open, 1'b0);
        rd(8'h06, 8'h0f, 8'h00);
        rd(8'h07, 8'h00, 8'h30);
        host_model_inst.write_reg(8'h06, 8'h12);
        check(open, 1'b1);
        // Mid-run reset must drop back to locked
        reset_n_in = 1'b0;
        repeat (2) @(posedge clock_in);
        #1;
        check({open, seg}, 5'h00);
        check({rdata, rvalid, avalid}, 10'h000);
        reset_n_in = 1'b1;
        rd(8'h06, 8'h0f, 8'h00);
        wrap_up();
    end
endmodule : ext_regs_tb
